// *** mmio_pkg.sv ***
// package of constants and carriers for the multi-mode i/o port pads
package mmio_pkg;
  // register byte offsets on the ahb-lite slave
  localparam logic [7:0] MMIO_OFS_P1_DATA  = 8'h00; // port1 data latch
  localparam logic [7:0] MMIO_OFS_P2_DATA  = 8'h04; // port2 data latch
  localparam logic [7:0] MMIO_OFS_P3_DATA  = 8'h08; // port3 data latch
  localparam logic [7:0] MMIO_OFS_P1_MODE  = 8'h0C; // port1 modes, 2 bits per pin
  localparam logic [7:0] MMIO_OFS_P3_MODE  = 8'h10; // port3 modes, 2 bits per pin
  localparam logic [7:0] MMIO_OFS_P2_MODE  = 8'h14; // p2.1..0 modes, bits 3:0
  localparam logic [7:0] MMIO_OFS_P2_OE    = 8'h18; // upper port2 output enable, bits 5:2
  localparam logic [7:0] MMIO_OFS_P1_PIN   = 8'h1C; // port1 pin levels, read only
  localparam logic [7:0] MMIO_OFS_P2_PIN   = 8'h20; // port2 pin levels, read only
  localparam logic [7:0] MMIO_OFS_P3_PIN   = 8'h24; // port3 pin levels, read only
  localparam logic [7:0] MMIO_OFS_RMW      = 8'h28; // rmw command: op 9:8, bit 6:4, port 3:2
  localparam logic [7:0] MMIO_OFS_LED_EN   = 8'h2C; // led segment enables, bits 5:0
  // reset values of latches and modes
  localparam logic [7:0] MMIO_RST_P1  = 8'hFF; // port1 latch after reset
  localparam logic [7:0] MMIO_RST_P2  = 8'h03; // port2 latch after reset
  localparam logic [7:0] MMIO_RST_P3  = 8'hFF; // port3 latch after reset
  localparam logic [15:0] MMIO_RST_MODE = 16'h0000; // all pins in mode 0
  // pseudo open drain strong-high pulse, in cycles
  localparam int MMIO_POD_CYCLES = 2; // strong drive cycles after low-to-high
  // pad modes
  typedef enum logic [1:0] {
    MMIO_MODE_PU  = 2'h0, // open drain with pull-up
    MMIO_MODE_OD  = 2'h1, // open drain, hi-z
    MMIO_MODE_PP  = 2'h2, // push-pull
    MMIO_MODE_ANA = 2'h3  // analog input
  } mmio_mode_t;
  // rmw operations
  typedef enum logic [1:0] {
    MMIO_RMW_SET = 2'h0, // set bit
    MMIO_RMW_CLR = 2'h1, // clear bit
    MMIO_RMW_CPL = 2'h2, // complement bit
    MMIO_RMW_INC = 2'h3  // increment whole latch
  } mmio_rmw_t;
  // per-pin pad control carrier
  typedef struct packed {
    logic oe;  // strong driver enable
    logic out; // driven level
    logic pu;  // weak pull-up enable
    logic ie;  // digital input buffer enable
    logic ana; // analog switch to converter
  } mmio_pad_t;
  // ahb-lite address phase carrier
  typedef struct packed {
    logic       valid; // pending data phase
    logic       write; // direction
    logic [7:0] addr;  // byte offset
  } mmio_aphase_t;
  // fsm of the slave
  typedef enum logic [1:0] {
    MMIO_ST_IDLE = 2'b01, // waiting
    MMIO_ST_DATA = 2'b10  // data phase
  } mmio_state_t;
endpackage

// *** mmio_port.sv ***
// multi-mode i/o port pad logic with ahb-lite register slave
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
// Operation
// RL1: rmw commands read latch, write latch back
// RL2: mode 2 push-pull, no pull-up, input; the input buffer is left off here, so the pin reads zero
// RL3: modes 0/1 drive low, 1 releases
// RL4: mode 3 analog, input and pull-up off
// RL5: upper port2 steered by output enable
// RL6: software picks mode 0/1, latch 1
// RL7: mode 3 activates converter channel
// RL8: auxiliary inputs need mode 0/1, latch 1
// RL9: port1/port3 wake-up and fixed functions
// RL10: thirty multi-function pins in total; this port has 22 pads (p1, p3, p2.5..0)
// RL11: pseudo open drain short strong high
// RL12: led segment overrides every other function
// RL13: disabled input buffer reads zero
module mmio_port
  import mmio_pkg::*;
#(
  parameter int NPIN = 30 // total pins
) (
  input  wire logic        hclk,        // system clock
  input  wire logic        hresetn,     // async reset, low
  input  wire logic        hsel,        // slave select
  input  wire logic [31:0] haddr,       // address
  input  wire logic [1:0]  htrans,      // transfer type
  input  wire logic        hwrite,      // write
  input  wire logic [2:0]  hsize,       // size
  input  wire logic [31:0] hwdata,      // write data
  input  wire logic        hready,      // bus ready
  output logic      [31:0] hrdata,      // read data
  output logic             hreadyout,   // slave ready
  output logic             hresp,       // response
  input  wire logic [7:0]  p1_in,       // port1 pad levels
  input  wire logic [7:0]  p2_in,       // port2 pad levels, 5:0 used
  input  wire logic [7:0]  p3_in,       // port3 pad levels
  output logic      [21:0] pad_o,       // pad level, order p1,p3,p2
  output logic      [21:0] pad_oe,      // strong driver on
  output logic      [21:0] pad_pu,      // weak pull-up/keeper on
  output logic      [21:0] pad_ana,     // analog switch on
  input  wire logic [5:0]  led_seg,     // led segment waveforms
  output logic      [5:0]  led_seg_en,  // led segment enables
  output logic      [15:0] wake_lvl,    // wake pin levels p1,p3
  output logic             ext_int0,    // external interrupt 0
  output logic             ext_int1,    // external interrupt 1
  output logic             ext_int2,    // external interrupt 2
  output logic             external_reset_input // reset pin level
);
  //////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    mmio_aphase_t ap;        // latched address phase
    mmio_state_t  st;        // slave state
    logic [7:0]   p1;        // port1 latch
    logic [7:0]   p2;        // port2 latch
    logic [7:0]   p3;        // port3 latch
    logic [15:0]  m1;        // port1 modes
    logic [15:0]  m3;        // port3 modes
    logic [3:0]   m2;        // p2.1..0 modes
    logic [3:0]   upper_port2_output_enable; // p2.5..2 oe
    logic [5:0]   led_en;    // led enables
    logic [2:0]   pod_prev;  // previous p3.2..0 latch
    logic [5:0]   pod_cnt;   // strong-high counters, 2 bits each
    logic [21:0]  s1;        // sync stage 1
    logic [21:0]  s2;        // sync stage 2
    logic [31:0]  rdata;     // registered read data
  } mmio_st_t;
  mmio_st_t st_r;  // current state
  mmio_st_t st_nxt; // next state

  //////////////////////////////////////////////////////////////////////
  // helpers
  // four-mode pad control for one pin
  function automatic mmio_pad_t four_mode(input logic [1:0] m, input logic d,
                                          input logic pod_hi);
    mmio_pad_t p;
    p = '0;
    case (m)
      MMIO_MODE_PU: begin // RL3
        p.oe  = ~d | pod_hi; // RL11
        p.out = d;
        p.pu  = d;
        p.ie  = d;
      end
      MMIO_MODE_OD: begin // RL3
        p.oe  = ~d | pod_hi; // RL11
        p.out = d;
        p.ie  = d;
      end
      MMIO_MODE_PP: begin // RL2
        p.oe  = 1'b1;
        p.out = d;
      end
      default: begin // RL4 RL7
        p.ana = 1'b1;
      end
    endcase
    return p;
  endfunction
  // read-modify-write on a latch value
  function automatic logic [7:0] rmw(input logic [7:0] v, input logic [1:0] op,
                                     input logic [2:0] b);
    logic [7:0] r;
    r = v;
    case (op)
      MMIO_RMW_SET: r[b] = 1'b1;
      MMIO_RMW_CLR: r[b] = 1'b0;
      MMIO_RMW_CPL: r[b] = ~v[b];
      default:      r = v + 8'h01;
    endcase
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // pad decode
  // four-mode pins first, then the oe-steered upper port2 pins
  mmio_pad_t pads [22]; // per pin control, led not yet applied
  logic [21:0] ie_vec;  // input buffer enables
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pads[i] = four_mode(st_r.m1[2*i +: 2], st_r.p1[i], 1'b0);
      pads[8+i] = four_mode(st_r.m3[2*i +: 2], st_r.p3[i],
                            (i < 3) ? (st_r.pod_cnt[2*(i%3) +: 2] != 2'h0) : 1'b0);
    end
    for (int i = 0; i < 2; i++) begin
      pads[16+i] = four_mode(st_r.m2[2*i +: 2], st_r.p2[i], 1'b0);
    end
    for (int i = 0; i < 4; i++) begin // RL5
      pads[18+i]     = '0;
      pads[18+i].oe  = st_r.upper_port2_output_enable[i];
      pads[18+i].out = st_r.p2[2+i];
      pads[18+i].pu  = ~st_r.upper_port2_output_enable[i] & st_r.p2[2+i];
      pads[18+i].ie  = ~st_r.upper_port2_output_enable[i];
    end
  end
  // pad outputs with led override, led pins p3.7..4 and p2.1..0
  always_comb begin
    int idx; // pad index of segment k
    idx = 0;
    for (int i = 0; i < 22; i++) begin
      pad_o[i]   = pads[i].out;
      pad_oe[i]  = pads[i].oe;
      pad_pu[i]  = pads[i].pu;
      pad_ana[i] = pads[i].ana;
      ie_vec[i]  = pads[i].ie;
    end
    // RL12: led segments 0,1 on p2.0/1, 2 on p3.7, 3..5 on p3.4..6
    for (int k = 0; k < 6; k++) begin
      idx = (k < 2) ? 16 + k : (k == 2) ? 15 : 9 + k;
      if (st_r.led_en[k]) begin
        pad_o[idx]   = led_seg[k]; // RL12
        pad_oe[idx]  = 1'b1;
        pad_pu[idx]  = 1'b0;
        pad_ana[idx] = 1'b0;
        ie_vec[idx]  = 1'b0;
      end
    end
  end
  // gated pin levels, zero when input disabled
  logic [21:0] pin_lvl; // RL13
  assign pin_lvl = st_r.s2 & ie_vec; // RL13
  // fixed function routing, relies on software settings of RL6 RL8
  assign wake_lvl   = pin_lvl[15:0]; // RL9 RL10
  assign ext_int0   = pin_lvl[10];   // RL9
  assign ext_int1   = pin_lvl[11];   // RL9
  assign ext_int2   = pin_lvl[15];   // RL9
  assign external_reset_input = pin_lvl[15]; // RL9
  assign led_seg_en = st_r.led_en;

  //////////////////////////////////////////////////////////////////////
  // bus outputs
  // zero wait states: every transfer completes in its data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_r.rdata;

  //////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [7:0] a;   // data phase address
    logic [1:0] op;  // rmw op
    logic [2:0] bt;  // rmw bit
    st_nxt = st_r;
    a  = st_r.ap.addr;
    op = hwdata[9:8];
    bt = hwdata[6:4];
    // synchronisers, stage 1 read only by stage 2
    st_nxt.s1 = {p2_in[5:0], p3_in, p1_in};
    // stage 1 already holds pad order p1,p3,p2
    st_nxt.s2 = st_r.s1;
    // pseudo open drain: strong high for two cycles on rise
    // strong drive starts the cycle after the latch rises
    for (int i = 0; i < 3; i++) begin
      if (st_r.p3[i] & ~st_r.pod_prev[i])
        st_nxt.pod_cnt[2*i +: 2] = 2'(MMIO_POD_CYCLES); // RL11
      else if (st_r.pod_cnt[2*i +: 2] != 2'h0)
        st_nxt.pod_cnt[2*i +: 2] = st_r.pod_cnt[2*i +: 2] - 2'h1;
    end
    st_nxt.pod_prev = st_r.p3[2:0];
    // write data phase
    if (st_r.ap.valid && st_r.ap.write) begin
      case (a)
        MMIO_OFS_P1_DATA: st_nxt.p1 = hwdata[7:0];
        MMIO_OFS_P2_DATA: st_nxt.p2 = {2'h0, hwdata[5:0]};
        MMIO_OFS_P3_DATA: st_nxt.p3 = hwdata[7:0];
        MMIO_OFS_P1_MODE: st_nxt.m1 = hwdata[15:0];
        MMIO_OFS_P3_MODE: st_nxt.m3 = hwdata[15:0];
        MMIO_OFS_P2_MODE: st_nxt.m2 = hwdata[3:0];
        MMIO_OFS_P2_OE:   st_nxt.upper_port2_output_enable = hwdata[5:2];
        MMIO_OFS_LED_EN:  st_nxt.led_en = hwdata[5:0];
        MMIO_OFS_RMW: begin // RL1
          case (hwdata[3:2])
            2'h0:    st_nxt.p1 = rmw(st_r.p1, op, bt); // RL1
            2'h1:    st_nxt.p2 = rmw(st_r.p2, op, bt) & 8'h3F; // RL1
            default: st_nxt.p3 = rmw(st_r.p3, op, bt); // RL1
          endcase
        end
        default: ;
      endcase
    end
    // address phase capture
    // read data comes from next state, so a read right after a write sees it
    if (hready) begin
      st_nxt.ap.valid = hsel & htrans[1];
      st_nxt.ap.write = hwrite;
      st_nxt.ap.addr  = haddr[7:0];
      st_nxt.st       = (hsel & htrans[1]) ? MMIO_ST_DATA : MMIO_ST_IDLE;
      st_nxt.rdata    = 32'h0000_0000;
      if (hsel & htrans[1] & ~hwrite) begin
        case (haddr[7:0])
          MMIO_OFS_P1_DATA: st_nxt.rdata = {24'h0, st_nxt.p1};
          MMIO_OFS_P2_DATA: st_nxt.rdata = {24'h0, st_nxt.p2};
          MMIO_OFS_P3_DATA: st_nxt.rdata = {24'h0, st_nxt.p3};
          MMIO_OFS_P1_MODE: st_nxt.rdata = {16'h0, st_nxt.m1};
          MMIO_OFS_P3_MODE: st_nxt.rdata = {16'h0, st_nxt.m3};
          MMIO_OFS_P2_MODE: st_nxt.rdata = {28'h0, st_nxt.m2};
          MMIO_OFS_P2_OE:   st_nxt.rdata = {26'h0, st_nxt.upper_port2_output_enable, 2'h0};
          MMIO_OFS_P1_PIN:  st_nxt.rdata = {24'h0, pin_lvl[7:0]};
          MMIO_OFS_P3_PIN:  st_nxt.rdata = {24'h0, pin_lvl[15:8]};
          MMIO_OFS_P2_PIN:  st_nxt.rdata = {26'h0, pin_lvl[21:16]};
          MMIO_OFS_LED_EN:  st_nxt.rdata = {26'h0, st_nxt.led_en};
          default:          st_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register
  // reset loads the latch and mode values a fresh part starts with
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r      <= '0;
      st_r.st   <= MMIO_ST_IDLE;
      st_r.p1   <= MMIO_RST_P1;
      st_r.p2   <= MMIO_RST_P2;
      st_r.p3   <= MMIO_RST_P3;
      st_r.m1   <= MMIO_RST_MODE;
      st_r.m3   <= MMIO_RST_MODE;
      st_r.pod_prev <= MMIO_RST_P3[2:0];
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // assertions
  // mode checks watch port1 pin 0, the pin whose modes are all exercised, except the mode 0 low check, which watches pin 1
  a_mode2_drive: assert property (@(posedge hclk) disable iff (!hresetn) // RL2
    (st_r.m1[1:0] == MMIO_MODE_PP && !st_r.led_en[0])
      |-> (pad_oe[0] && pad_o[0] == st_r.p1[0] && !pad_pu[0]))
    else $error("mode 2 pad not push-pull");
  a_mode0_low: assert property (@(posedge hclk) disable iff (!hresetn) // RL3
    (st_r.m1[3:2] == MMIO_MODE_PU && !st_r.p1[1]) |-> (pad_oe[1] && !pad_o[1] && !pad_pu[1]))
    else $error("mode 0 low not driven");
  a_mode1_hiz: assert property (@(posedge hclk) disable iff (!hresetn) // RL3
    (st_r.m1[1:0] == MMIO_MODE_OD && st_r.p1[0]) |-> (!pad_oe[0] && !pad_pu[0]))
    else $error("mode 1 high not released");
  a_mode3_ana: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
    (st_r.m1[1:0] == MMIO_MODE_ANA) |-> (pad_ana[0] && !pad_oe[0] && !pad_pu[0]))
    else $error("mode 3 not analog");
  a_upper_oe: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
    pad_oe[18] == st_r.upper_port2_output_enable[0])
    else $error("upper port2 oe mismatch");
  a_pod_pulse: assert property (@(posedge hclk) disable iff (!hresetn) // RL11
    (st_r.m3[1:0] == MMIO_MODE_OD && $rose(st_r.p3[0])) |=> pad_oe[8] ##1 pad_oe[8] ##1 !pad_oe[8])
    else $error("pseudo open drain pulse wrong");
  a_led_wins: assert property (@(posedge hclk) disable iff (!hresetn) // RL12
    st_r.led_en[2] |-> (pad_oe[15] && pad_o[15] == led_seg[2]))
    else $error("led segment not overriding");
  a_pin_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RL13
    (st_r.m1[1:0] == MMIO_MODE_ANA) |-> !wake_lvl[0])
    else $error("disabled input not zero");
  a_rmw_latch: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
    (st_r.ap.valid && st_r.ap.write && st_r.ap.addr == MMIO_OFS_RMW
     && hwdata[3:2] == 2'h0 && hwdata[9:8] == 2'h2 && hwdata[6:4] == 3'h4)
      |=> st_r.p1[4] == !$past(st_r.p1[4]))
    else $error("rmw did not use latch");
  c_rmw: cover property (@(posedge hclk) st_r.ap.valid && st_r.ap.addr == MMIO_OFS_RMW);
  c_mode3: cover property (@(posedge hclk) pad_ana[0]);
  c_led: cover property (@(posedge hclk) st_r.led_en != 6'h00);
  c_pod: cover property (@(posedge hclk) pad_oe[8] && st_r.p3[0]);
  c_upper: cover property (@(posedge hclk) pad_oe[18]);
endmodule

// *** mmio_pins.sv ***
// external circuitry model loading and driving the port pins
`timescale 1ns/1ps
module mmio_pins
  import mmio_pkg::*;
(
  input  wire logic        hclk,    // system clock
  input  wire logic [21:0] pad_o,   // pad level from the port
  input  wire logic [21:0] pad_oe,  // strong driver on
  input  wire logic [21:0] pad_pu,  // weak pull-up on
  input  wire logic [21:0] ext_drv, // level of the outside circuit
  input  wire logic [21:0] ext_en,  // outside circuit drives
  output logic      [7:0]  p1_in,   // port1 levels
  output logic      [7:0]  p2_in,   // port2 levels
  output logic      [7:0]  p3_in    // port3 levels
);
  logic [21:0] drift_r; // floating pins wander every cycle
  logic [21:0] lvl;     // resolved wire level
  initial drift_r = 22'h155555;
  // a released, unpulled wire never holds its last value
  always @(posedge hclk) drift_r <= ~drift_r;
  // strong driver beats outside circuit, which beats weak pull-up
  always_comb begin
    for (int i = 0; i < 22; i++) begin
      if (pad_oe[i]) lvl[i] = pad_o[i];
      else if (ext_en[i]) lvl[i] = ext_drv[i];
      else if (pad_pu[i]) lvl[i] = 1'b1;
      else lvl[i] = drift_r[i];
    end
  end
  assign p1_in = lvl[7:0];
  assign p3_in = lvl[15:8];
  assign p2_in = {2'h0, lvl[21:16]};
endmodule

// *** tb.sv ***
// self-checking bench for the multi-mode port pads
`timescale 1ns/1ps
module tb
  import mmio_pkg::*;
;
  typedef struct packed {
    logic       p2;  // upper port2 pin instead of port1 pin
    logic [1:0] cfg; // mode, or output enable in bit 0
    logic       lat; // latch value
    logic [4:0] exp; // oe, driven level, pull-up, analog, pin read
  } mmio_row_t;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  p1_in, p2_in, p3_in;
  logic [21:0] pad_o, pad_oe, pad_pu, pad_ana, ext_drv, ext_en;
  logic [5:0]  led_seg, led_seg_en;
  logic [15:0] wake_lvl;
  logic        ext_int0, ext_int1, ext_int2, rst_pin;
  int          bad_count, checks, k, cnt;
  mmio_row_t   rows [12];
  mmio_port dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .p1_in(p1_in), .p2_in(p2_in),
    .p3_in(p3_in), .pad_o(pad_o), .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_ana(pad_ana),
    .led_seg(led_seg), .led_seg_en(led_seg_en), .wake_lvl(wake_lvl), .ext_int0(ext_int0),
    .ext_int1(ext_int1), .ext_int2(ext_int2), .external_reset_input(rst_pin));
  mmio_pins pins_u (.hclk(hclk), .pad_o(pad_o), .pad_oe(pad_oe), .pad_pu(pad_pu),
    .ext_drv(ext_drv), .ext_en(ext_en), .p1_in(p1_in), .p2_in(p2_in), .p3_in(p3_in));
  ////////////////////////////////////////////////////////////////////////////////
  // clock, 40 ns period
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one ahb-lite single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // read and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask
  // rmw command on port1
  task automatic rmw(input logic [1:0] op, input logic [2:0] b);
    bus(1'b1, MMIO_OFS_RMW, {22'h0, op, 1'b0, b, 4'h0});
  endtask
  // verdict
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    #400us;
    bad_count++;
    tally_and_finish;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata, led_seg} = '0;
    ext_drv = '1;
    ext_en = '1;
    hresetn = 1'b0;
    rows = '{'{0,0,0,5'h10}, '{0,0,1,5'h05}, '{0,1,0,5'h10}, '{0,1,1,5'h01},
             '{0,2,0,5'h10}, '{0,2,1,5'h18}, '{0,3,0,5'h02}, '{0,3,1,5'h02},
             '{1,0,0,5'h01}, '{1,0,1,5'h05}, '{1,1,0,5'h10}, '{1,1,1,5'h18}};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset state
    rdc(MMIO_OFS_P1_DATA, {24'h0, MMIO_RST_P1}, "p1 latch");
    rdc(MMIO_OFS_P2_DATA, {24'h0, MMIO_RST_P2}, "p2 latch");
    rdc(MMIO_OFS_P3_DATA, {24'h0, MMIO_RST_P3}, "p3 latch");
    rdc(MMIO_OFS_P1_MODE, 32'h0, "p1 mode");
    chk({10'h0, pad_pu}, 32'h03FFFF, "reset pull-ups");
    chk({10'h0, pad_oe}, 32'h0, "reset drivers");
    $display("test reset done");
    // pad table for every mode and enable
    foreach (rows[i]) begin
      if (!rows[i].p2) begin
        bus(1'b1, MMIO_OFS_P1_MODE, {30'h0, rows[i].cfg});
        bus(1'b1, MMIO_OFS_P1_DATA, {31'h0, rows[i].lat});
        k = 0;
      end else begin
        bus(1'b1, MMIO_OFS_P2_OE, {29'h0, rows[i].cfg[0], 2'h0});
        bus(1'b1, MMIO_OFS_P2_DATA, {29'h0, rows[i].lat, 2'h3});
        k = 18;
      end
      repeat (3) @(posedge hclk);
      bus(1'b0, rows[i].p2 ? MMIO_OFS_P2_PIN : MMIO_OFS_P1_PIN, 32'h0);
      chk({pad_oe[k], pad_oe[k] & pad_o[k], pad_pu[k], pad_ana[k], rd[k ? 2 : 0]},
          rows[i].exp, "pad row");
    end
    $display("test pad table done");
    // wake levels and fixed functions, mode 0 latch 1
    bus(1'b1, MMIO_OFS_P1_MODE, 32'h0);
    bus(1'b1, MMIO_OFS_P1_DATA, 32'hFF);
    ext_drv[15:0] <= 16'h44A5;
    repeat (4) @(posedge hclk);
    chk({16'h0, wake_lvl}, 32'h44A5, "wake levels");
    chk({ext_int0, ext_int1, ext_int2, rst_pin}, 4'h8, "fixed functions a");
    ext_drv[15:8] <= 8'h88;
    repeat (4) @(posedge hclk);
    chk({ext_int0, ext_int1, ext_int2, rst_pin}, 4'h7, "fixed functions b");
    $display("test wake done");
    // rmw uses latch while outside pulls every port1 pin low
    ext_drv[7:0] <= 8'h00;
    bus(1'b1, MMIO_OFS_P1_DATA, 32'hF0);
    rmw(MMIO_RMW_SET, 3'h1);
    rdc(MMIO_OFS_P1_DATA, 32'hF2, "rmw set");
    rmw(MMIO_RMW_CLR, 3'h7);
    rdc(MMIO_OFS_P1_DATA, 32'h72, "rmw clear");
    rmw(MMIO_RMW_CPL, 3'h4);
    rdc(MMIO_OFS_P1_DATA, 32'h62, "rmw complement");
    rmw(MMIO_RMW_INC, 3'h0);
    rdc(MMIO_OFS_P1_DATA, 32'h63, "rmw increment");
    rdc(MMIO_OFS_P1_PIN, 32'h0, "p1 pins low");
    $display("test rmw done");
    // pseudo open drain strong high pulse on p3.0
    ext_drv <= '1;
    bus(1'b1, MMIO_OFS_P3_MODE, 32'h1);
    bus(1'b1, MMIO_OFS_P3_DATA, 32'hFE);
    bus(1'b1, MMIO_OFS_P3_DATA, 32'hFF);
    cnt = 0;
    repeat (6) begin
      @(negedge hclk);
      if (pad_oe[8] === 1'b1 && pad_o[8] === 1'b1) cnt++;
    end
    chk(cnt, MMIO_POD_CYCLES, "strong high cycles");
    $display("test pseudo open drain done");
    // led segment overrides p3.7
    bus(1'b1, MMIO_OFS_LED_EN, 32'h4);
    led_seg <= 6'h04;
    @(posedge hclk);
    chk({led_seg_en, pad_oe[15], pad_o[15]}, {6'h04, 2'h3}, "led high");
    led_seg <= 6'h00;
    @(posedge hclk);
    chk({pad_oe[15], pad_o[15]}, 2'h2, "led low");
    rdc(MMIO_OFS_P3_PIN, 32'h7F, "led pin gated");
    $display("test led done");
    // port2 low pin in push-pull, rmw on port2 and port3
    bus(1'b1, MMIO_OFS_P2_MODE, 32'h2);
    bus(1'b1, MMIO_OFS_P2_DATA, 32'h3F);
    @(posedge hclk);
    chk({pad_oe[16], pad_o[16], pad_pu[16]}, 3'h6, "p2.0 push-pull");
    rdc(MMIO_OFS_P2_MODE, 32'h2, "p2 mode");
    bus(1'b1, MMIO_OFS_RMW, {22'h0, MMIO_RMW_INC, 1'b0, 3'h0, 4'h4});
    rdc(MMIO_OFS_P2_DATA, 32'h0, "rmw p2 increment");
    bus(1'b1, MMIO_OFS_RMW, {22'h0, MMIO_RMW_CLR, 1'b0, 3'h7, 4'h8});
    rdc(MMIO_OFS_P3_DATA, 32'h7F, "rmw p3 clear");
    $display("test port2 port3 done");
    // second reset in mid-run restores latches, modes and enables
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({10'h0, pad_oe}, 32'h0, "mid reset drivers");
    rdc(MMIO_OFS_P1_DATA, {24'h0, MMIO_RST_P1}, "mid reset p1 latch");
    rdc(MMIO_OFS_P3_MODE, 32'h0, "mid reset p3 mode");
    rdc(MMIO_OFS_LED_EN, 32'h0, "mid reset led");
    $display("test mid reset done");
    // unmapped address
    bus(1'b1, 8'h30, 32'hFFFFFFFF);
    chk({31'h0, hresp}, 32'h0, "okay response");
    rdc(8'h30, 32'h0, "unmapped");
    rdc(MMIO_OFS_P1_DATA, {24'h0, MMIO_RST_P1}, "unmapped write ignored");
    $display("test unmapped done");
    tally_and_finish;
  end
endmodule
